// ### logic/sci_cmd_input.sv
// Summary of operation
// RQ1 - Run input asserted turns servo on and powers motor; deasserted removes power.
// RQ2 - Host holds alarm reset asserted at least 120 ms to be recognised.
// RQ3 - Valid alarm reset clears the alarm, except alarms marked as not clearable.
// RQ4 - Mode 0 or 2 means position control, mode 1 internal speed control.
// RQ5 - Position mode: deviation clear drops command pulses and holds counter at zero.
// RQ6 - Host holds deviation clear asserted at least 2 ms.
// RQ7 - Speed mode: deviation clear pin is preset speed select bit 2.
// RQ8 - Position mode, function 0 or 1: shared pin acts as gain switch.
// RQ9 - Speed mode, function 1: zero speed input low forces zero speed; 0 ignores.
// RQ10 - Position mode: gear pin low picks numerator one, high numerator two.
// RQ11 - Host sends no pulses 10 ms before and after changing gear pin.
// RQ12 - Speed mode: gear switch pin is preset speed select bit 1.
// RQ13 - Overtravel input low forbids motion that way; high permits it.
// RQ14 - Pulse inputs accept 500 kpps line driver, 200 kpps open collector.
// RQ15 - Pulse format picks forward/reverse trains, pulse with direction, or quadrature.
// RQ16 - Pair one: reverse, feed or phase A; pair two: forward, direction or B.
// RQ17 - Each pulse moves command one unit, scaled by gear numerator, into deviation.
`timescale 1ns/100ps
module sci_cmd_input import sci_pkg::*; #(
    parameter int GEAR_W = GEAR_W_DEF,
    parameter int DEV_W = DEV_W_DEF,
    parameter int ALM_RST_CYCLES = ALM_RST_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run_in,
    input wire logic alarm_reset_in,
    input wire logic deviation_clear_in,
    input wire logic gain_switch_in,
    input wire logic gear_switch_in,
    input wire logic forward_overtravel_in,
    input wire logic reverse_overtravel_in,
    input wire logic cmd_pair1_in,
    input wire logic cmd_pair2_in,
    input wire logic [1:0] control_mode_param,
    input wire logic [1:0] zero_speed_function_param,
    input wire logic [1:0] pulse_format_param,
    input wire logic [GEAR_W-1:0] gear_numerator_one,
    input wire logic [GEAR_W-1:0] gear_numerator_two,
    input wire logic alarm_raise,
    input wire logic alarm_clearable,
    input wire logic fb_step,
    input wire logic fb_step_fwd,
    output logic motor_enable,
    output logic servo_alarm,
    output logic alarm_reset_done,
    output logic position_mode,
    output logic gain_select,
    output logic torque_limit_select,
    output logic speed_force_zero,
    output logic [1:0] preset_speed_sel,
    output logic forward_permit,
    output logic reverse_permit,
    output logic signed [DEV_W-1:0] deviation_count,
    output logic signed [DEV_W-1:0] position_cmd
);

    // Elaboration checks: counter must hold a signed numerator, rate must be resolvable
    if (DEV_W <= GEAR_W + 1) begin : g_bad_width
        $error("deviation width must exceed gear numerator width by two");
    end
    if (ALM_RST_CYCLES < 1) begin : g_bad_alm
        $error("alarm reset hold count must be at least one");
    end
    if (PULSE_HALF_CYC < PULSE_HALF_MIN_CYC) begin : g_bad_rate // RQ14
        $error("core clock too slow for the highest command pulse rate");
    end

    localparam int ARC_W = $clog2(ALM_RST_CYCLES + 1);
    localparam logic [ARC_W-1:0] ARC_LAST = ARC_W'(ALM_RST_CYCLES - 1);

    typedef enum logic [1:0] {
        ARS_IDLE,
        ARS_COUNT,
        ARS_HELD
    } sci_ars_e;

    // Pin inputs, synchronised
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pins_async;
    logic [NSYNC-1:0] pins_sync;
    logic run_s;
    logic arst_s;
    logic dclr_s;
    logic gain_s;
    logic gear_s;
    logic fot_s;
    logic rot_s;
    logic pair1_s;
    logic pair2_s;

    assign pins_async = {run_in, alarm_reset_in, deviation_clear_in, gain_switch_in,
                         gear_switch_in, forward_overtravel_in, reverse_overtravel_in,
                         cmd_pair1_in, cmd_pair2_in};
    assign {run_s, arst_s, dclr_s, gain_s, gear_s, fot_s, rot_s, pair1_s, pair2_s} = pins_sync;

    sci_sync #(
        .W(NSYNC)
    ) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    // Command pulse decode
    logic cmd_step;
    logic cmd_fwd;

    sci_pulse_decode u_decode (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .fmt(pulse_format_param),
        .pair1(pair1_s),
        .pair2(pair2_s),
        .step(cmd_step),
        .step_fwd(cmd_fwd)
    );

    // Alarm reset qualification state
    sci_ars_e ars_r;
    sci_ars_e ars_nxt;
    logic [ARC_W-1:0] arc_r;
    logic [ARC_W-1:0] arc_nxt;
    logic ars_fire;

    // A request counts once per assertion and only after the full hold
    always_comb begin
        ars_nxt = ars_r;
        arc_nxt = arc_r;
        ars_fire = 1'b0;
        unique case (ars_r)
            ARS_IDLE: begin
                arc_nxt = '0;
                if (arst_s) begin
                    ars_nxt = ARS_COUNT;
                end
            end
            ARS_COUNT: begin
                if (!arst_s) begin
                    ars_nxt = ARS_IDLE;
                end else if (arc_r == ARC_LAST) begin // RQ2
                    ars_fire = 1'b1;
                    ars_nxt = ARS_HELD;
                end else begin
                    arc_nxt = arc_r + ARC_W'(1);
                end
            end
            ARS_HELD: begin
                if (!arst_s) begin
                    ars_nxt = ARS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ars_r <= ARS_IDLE;
            arc_r <= '0;
        end else begin
            ars_r <= ars_nxt;
            arc_r <= arc_nxt;
        end
    end

    // Alarm status and servo enable
    logic alarm_r;
    logic alarm_nxt;
    logic alarm_lock_r;
    logic alarm_lock_nxt;
    logic arst_done_r;
    logic arst_done_nxt;
    logic motor_en_r;
    logic motor_en_nxt;

    // A new alarm in the clearing cycle wins; locked alarms survive an alarm reset
    always_comb begin
        alarm_nxt = alarm_r;
        alarm_lock_nxt = alarm_lock_r;
        arst_done_nxt = 1'b0;
        if (ars_fire && !alarm_lock_r) begin // RQ3
            alarm_nxt = 1'b0;
            arst_done_nxt = alarm_r;
        end
        if (alarm_raise) begin
            alarm_nxt = 1'b1;
            alarm_lock_nxt = alarm_lock_r | ~alarm_clearable;
            arst_done_nxt = 1'b0;
        end
        // Servo on only while run is held and no alarm stands
        motor_en_nxt = run_s & ~alarm_nxt; // RQ1
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            alarm_r <= 1'b0;
            alarm_lock_r <= 1'b0;
            arst_done_r <= 1'b0;
            motor_en_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
            alarm_lock_r <= alarm_lock_nxt;
            arst_done_r <= arst_done_nxt;
            motor_en_r <= motor_en_nxt;
        end
    end

    // Shared pin meaning by control mode
    logic pos_mode_r;
    logic pos_mode_nxt;
    logic gain_r;
    logic gain_nxt;
    logic tlim_r;
    logic tlim_nxt;
    logic zero_speed_in_r;
    logic zero_speed_in_nxt;
    logic [1:0] vsel_r;
    logic [1:0] vsel_nxt;
    logic fperm_r;
    logic fperm_nxt;
    logic rperm_r;
    logic rperm_nxt;
    logic speed_mode;

    always_comb begin
        speed_mode = sci_is_speed_mode(control_mode_param); // RQ4
        pos_mode_nxt = sci_is_pos_mode(control_mode_param); // RQ4
        gain_nxt = pos_mode_nxt & gain_s &
                   ((zero_speed_function_param == ZSF_OFF) ||
                    (zero_speed_function_param == ZSF_ZERO_EN)); // RQ8
        tlim_nxt = pos_mode_nxt & gain_s & (zero_speed_function_param == ZSF_TLIM);
        // Zero speed input is active low and only counts when enabled
        zero_speed_in_nxt = speed_mode & ~gain_s & (zero_speed_function_param == ZSF_ZERO_EN); // RQ9
        vsel_nxt = speed_mode ? {dclr_s, gear_s} : 2'h0; // RQ7 RQ12
        fperm_nxt = fot_s; // RQ13
        rperm_nxt = rot_s; // RQ13
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pos_mode_r <= 1'b0;
            gain_r <= 1'b0;
            tlim_r <= 1'b0;
            zero_speed_in_r <= 1'b0;
            vsel_r <= 2'h0;
            fperm_r <= 1'b0;
            rperm_r <= 1'b0;
        end else begin
            pos_mode_r <= pos_mode_nxt;
            gain_r <= gain_nxt;
            tlim_r <= tlim_nxt;
            zero_speed_in_r <= zero_speed_in_nxt;
            vsel_r <= vsel_nxt;
            fperm_r <= fperm_nxt;
            rperm_r <= rperm_nxt;
        end
    end

    // Position command and deviation counter
    logic signed [DEV_W-1:0] dev_r;
    logic signed [DEV_W-1:0] dev_nxt;
    logic signed [DEV_W-1:0] pcmd_r;
    logic signed [DEV_W-1:0] pcmd_nxt;
    logic signed [DEV_W-1:0] scaled;
    logic signed [DEV_W-1:0] fb_delta;
    logic [GEAR_W-1:0] numer;
    logic take_step;

    // Pulses toward a blocked side are dropped so no deviation builds against the stop
    always_comb begin
        numer = gear_s ? gear_numerator_two : gear_numerator_one; // RQ10
        take_step = cmd_step & pos_mode_r & ~dclr_s & motor_en_r &
                    (cmd_fwd ? fperm_r : rperm_r); // RQ5 RQ13
        scaled = DEV_W'(numer);
        if (!cmd_fwd) begin
            scaled = -scaled;
        end
        fb_delta = fb_step ? (fb_step_fwd ? DEV_W'(1) : -DEV_W'(1)) : '0;
        pcmd_nxt = pcmd_r;
        dev_nxt = dev_r - fb_delta;
        if (take_step) begin // RQ17
            pcmd_nxt = pcmd_r + (cmd_fwd ? DEV_W'(1) : -DEV_W'(1));
            dev_nxt = dev_r + scaled - fb_delta;
        end
        // Clear also holds while servo is off, so no stale error jerks the motor
        if ((pos_mode_r && dclr_s) || !motor_en_r) begin // RQ5
            dev_nxt = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dev_r <= '0;
            pcmd_r <= '0;
        end else begin
            dev_r <= dev_nxt;
            pcmd_r <= pcmd_nxt;
        end
    end

    // Outputs, each straight from a register
    assign motor_enable = motor_en_r;
    assign servo_alarm = alarm_r;
    assign alarm_reset_done = arst_done_r;
    assign position_mode = pos_mode_r;
    assign gain_select = gain_r;
    assign torque_limit_select = tlim_r;
    assign speed_force_zero = zero_speed_in_r;
    assign preset_speed_sel = vsel_r;
    assign forward_permit = fperm_r;
    assign reverse_permit = rperm_r;
    assign deviation_count = dev_r;
    assign position_cmd = pcmd_r;

endmodule : sci_cmd_input

// ### logic/sci_pkg.sv
package sci_pkg;

    // Core clock rate
    localparam int CLK_HZ = 20_000_000;
    localparam int HZ_PER_KHZ = 1000;

    // Least hold time of the alarm reset input, and its cycle count
    localparam int ALM_RST_MIN_MS = 120;
    localparam int ALM_RST_CYC = (CLK_HZ / HZ_PER_KHZ) * ALM_RST_MIN_MS;

    // Highest command pulse rates, line driver and open collector
    localparam int RATE_LD_KPPS = 500;
    localparam int RATE_OC_KPPS = 200;
    // Shortest half period of a line-driver pulse train, in cycles (rounded down)
    localparam int PULSE_HALF_CYC = CLK_HZ / (HZ_PER_KHZ * RATE_LD_KPPS * 2);
    // Fewest cycles per half period that the edge detector can resolve
    localparam int PULSE_HALF_MIN_CYC = 2;

    // Control mode parameter codes
    localparam logic [1:0] MODE_POS_A = 2'h0;
    localparam logic [1:0] MODE_SPEED = 2'h1;
    localparam logic [1:0] MODE_POS_B = 2'h2;

    // Zero speed / torque limit function parameter codes
    localparam logic [1:0] ZSF_OFF = 2'h0;
    localparam logic [1:0] ZSF_ZERO_EN = 2'h1;
    localparam logic [1:0] ZSF_TLIM = 2'h2;

    // Pulse format parameter codes
    localparam logic [1:0] FMT_FWD_REV = 2'h0;
    localparam logic [1:0] FMT_PULSE_DIR = 2'h1;
    localparam logic [1:0] FMT_QUAD = 2'h2;

    // Default widths
    localparam int GEAR_W_DEF = 16;
    localparam int DEV_W_DEF = 28;

    // Internal speed control is selected by code 1 only
    function automatic logic sci_is_speed_mode(input logic [1:0] mode);
        sci_is_speed_mode = (mode == MODE_SPEED);
    endfunction : sci_is_speed_mode

    // Position control is codes 0 and 2; code 3 selects neither
    function automatic logic sci_is_pos_mode(input logic [1:0] mode);
        sci_is_pos_mode = (mode == MODE_POS_A) || (mode == MODE_POS_B);
    endfunction : sci_is_pos_mode

endpackage : sci_pkg

// ### logic/sci_sync.sv
`timescale 1ns/100ps
module sci_sync import sci_pkg::*; #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // First stage feeds only the second stage
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule : sci_sync

// ### logic/sci_pulse_decode.sv
`timescale 1ns/100ps
module sci_pulse_decode import sci_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [1:0] fmt,
    input wire logic pair1,
    input wire logic pair2,
    output logic step,
    output logic step_fwd
);

    logic p1_r;
    logic p1_nxt;
    logic p2_r;
    logic p2_nxt;
    logic step_r;
    logic step_nxt;
    logic fwd_r;
    logic fwd_nxt;
    logic rise1;
    logic rise2;
    logic chg1;
    logic chg2;

    // Edges against the previous synchronised sample
    always_comb begin
        p1_nxt = pair1;
        p2_nxt = pair2;
        rise1 = pair1 & ~p1_r;
        rise2 = pair2 & ~p2_r;
        chg1 = pair1 ^ p1_r;
        chg2 = pair2 ^ p2_r;
        step_nxt = 1'b0;
        fwd_nxt = fwd_r;
        unique case (fmt)
            FMT_FWD_REV: begin // RQ15 RQ16
                // Coincident edges cancel, so nothing moves
                step_nxt = rise1 ^ rise2;
                fwd_nxt = rise2 ? 1'b1 : 1'b0;
            end
            FMT_PULSE_DIR: begin // RQ15 RQ16
                step_nxt = rise1;
                fwd_nxt = pair2;
            end
            FMT_QUAD: begin // RQ15 RQ16
                // Four counts per cycle; a double change is a glitch and dropped
                step_nxt = chg1 ^ chg2;
                fwd_nxt = chg1 ? (pair1 ^ p2_r) : ~(pair2 ^ p1_r);
            end
            default: begin
                step_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            p1_r <= 1'b0;
            p2_r <= 1'b0;
            step_r <= 1'b0;
            fwd_r <= 1'b0;
        end else begin
            p1_r <= p1_nxt;
            p2_r <= p2_nxt;
            step_r <= step_nxt;
            fwd_r <= fwd_nxt;
        end
    end

    assign step = step_r;
    assign step_fwd = fwd_r;

endmodule : sci_pulse_decode

// ### testbench/sci_chk.sv
`timescale 1ns/100ps
module sci_chk import sci_pkg::*; #(
    parameter int DEV_W = DEV_W_DEF,
    parameter int ALM_RST_CYCLES = ALM_RST_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run_in,
    input wire logic alarm_reset_in,
    input wire logic deviation_clear_in,
    input wire logic gain_switch_in,
    input wire logic gear_switch_in,
    input wire logic forward_overtravel_in,
    input wire logic [1:0] control_mode_param,
    input wire logic [1:0] zero_speed_function_param,
    input wire logic alarm_raise,
    input wire logic alarm_clearable,
    input wire logic motor_enable,
    input wire logic servo_alarm,
    input wire logic position_mode,
    input wire logic gain_select,
    input wire logic speed_force_zero,
    input wire logic [1:0] preset_speed_sel,
    input wire logic forward_permit,
    input wire logic signed [DEV_W-1:0] deviation_count
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic [31:0] hold_r, hold_nxt;
    logic lock_r, lock_nxt;
    // Run length of the alarm reset pin; wraps only far beyond any run
    always_comb begin
        hold_nxt = alarm_reset_in ? hold_r + 32'h0000_0001 : 32'h0000_0000;
        lock_nxt = lock_r | (alarm_raise & ~alarm_clearable);
        if (sys_rst) begin
            hold_nxt = 32'h0000_0000;
            lock_nxt = 1'b0;
        end
    end
    // Helper registers only
    always_ff @(posedge core_clk) begin
        hold_r <= hold_nxt;
        lock_r <= lock_nxt;
    end

    a_run_on: assert property ((run_in && !servo_alarm)[*5] |-> motor_enable)
        else $error("motor not enabled while running");
    a_run_off: assert property (!run_in[*4] |-> !motor_enable)
        else $error("motor enabled without run");
    a_mode_map: assert property ($stable(control_mode_param)[*2] |-> position_mode ==
        (control_mode_param == MODE_POS_A || control_mode_param == MODE_POS_B))
        else $error("position mode flag wrong");
    a_speed_sel: assert property ((control_mode_param == MODE_SPEED &&
        $stable({deviation_clear_in, gear_switch_in}))[*5] |->
        preset_speed_sel == {deviation_clear_in, gear_switch_in})
        else $error("preset speed select wrong");
    a_gain_sw: assert property ((!control_mode_param[0] && !zero_speed_function_param[1] &&
        $stable(gain_switch_in))[*5] |-> gain_select == gain_switch_in)
        else $error("gain select wrong");
    a_zero_speed: assert property ((control_mode_param == MODE_SPEED &&
        zero_speed_function_param == ZSF_ZERO_EN && $stable(gain_switch_in))[*5] |->
        speed_force_zero == !gain_switch_in)
        else $error("zero speed force wrong");
    a_zero_off: assert property ((zero_speed_function_param == ZSF_OFF)[*2] |->
        !speed_force_zero)
        else $error("zero speed forced while disabled");
    a_fwd_permit: assert property ($stable(forward_overtravel_in)[*5] |->
        forward_permit == forward_overtravel_in)
        else $error("forward permit wrong");
    a_clear_zero: assert property ((!control_mode_param[0] && deviation_clear_in)[*6] |->
        deviation_count == '0)
        else $error("deviation not held at zero");
    a_reset_hold: assert property ($fell(servo_alarm) |-> hold_r >= ALM_RST_CYCLES)
        else $error("alarm cleared by short reset");
    a_lock_stays: assert property (lock_r |-> servo_alarm)
        else $error("locked alarm cleared");
endmodule : sci_chk

bind sci_cmd_input sci_chk #(.DEV_W(DEV_W), .ALM_RST_CYCLES(ALM_RST_CYCLES)) u_chk (
    .core_clk, .sys_rst, .run_in, .alarm_reset_in, .deviation_clear_in, .gain_switch_in,
    .gear_switch_in, .forward_overtravel_in, .control_mode_param,
    .zero_speed_function_param, .alarm_raise, .alarm_clearable, .motor_enable,
    .servo_alarm, .position_mode, .gain_select, .speed_force_zero, .preset_speed_sel,
    .forward_permit, .deviation_count);

// ### testbench/sci_host.sv
`timescale 1ns/100ps
module sci_host import sci_pkg::*; #(
    parameter int QUIET_CYC = 40,
    parameter int CLR_CYC = 40
) (
    input wire logic core_clk,
    output logic cmd_pair1_in,
    output logic cmd_pair2_in,
    output logic gear_switch_in,
    output logic alarm_reset_in,
    output logic deviation_clear_in
);
    logic [1:0] q;
    // Idle levels; pulse pins rest low so format changes make no edges
    initial begin
        {cmd_pair1_in, cmd_pair2_in, gear_switch_in, alarm_reset_in, deviation_clear_in} = '0;
        q = 2'h0;
    end
    // One pin change per half period holds the line-driver ceiling
    task automatic hp();
        repeat (PULSE_HALF_CYC) @(posedge core_clk);
    endtask : hp
    // Send n steps in format f; quadrature counts every phase change
    task automatic pulses(input logic [1:0] f, input int n, input logic fwd);
        @(posedge core_clk);
        if (f == FMT_PULSE_DIR) begin
            cmd_pair2_in <= fwd;
            hp();
        end
        for (int i = 0; i < n; i++) begin
            if (f == FMT_QUAD) begin
                q = fwd ? q + 2'h1 : q - 2'h1;
                cmd_pair1_in <= ^q;
                cmd_pair2_in <= q[1];
                hp();
            end else begin
                if (f == FMT_FWD_REV && fwd) cmd_pair2_in <= 1'b1;
                else cmd_pair1_in <= 1'b1;
                hp();
                if (f == FMT_FWD_REV && fwd) cmd_pair2_in <= 1'b0;
                else cmd_pair1_in <= 1'b0;
                hp();
            end
        end
        if (f == FMT_PULSE_DIR) cmd_pair2_in <= 1'b0;
        hp();
    endtask : pulses
    // Pulses stay quiet on both sides of a gear change
    task automatic set_gear(input logic v);
        repeat (QUIET_CYC) @(posedge core_clk);
        gear_switch_in <= v;
        repeat (QUIET_CYC) @(posedge core_clk);
    endtask : set_gear
    task automatic clear(input logic v);
        @(posedge core_clk);
        deviation_clear_in <= v;
        repeat (CLR_CYC) @(posedge core_clk);
    endtask : clear
    // A short n is a commanded fault; full requests hold past the minimum
    task automatic alm_reset(input int n);
        @(posedge core_clk);
        alarm_reset_in <= 1'b1;
        repeat (n) @(posedge core_clk);
        alarm_reset_in <= 1'b0;
        @(posedge core_clk);
    endtask : alm_reset
endmodule : sci_host

// ### testbench/sci_cmd_input_bench.sv
`timescale 1ns/100ps
module sci_cmd_input_bench import sci_pkg::*; ;
    localparam int ALM_N = 20;
    logic core_clk, sys_rst, run_in, gain_switch_in, alarm_raise, alarm_clearable;
    logic forward_overtravel_in, reverse_overtravel_in, done_seen, fb_step, fb_step_fwd;
    logic cmd_pair1_in, cmd_pair2_in, gear_switch_in, alarm_reset_in, deviation_clear_in;
    logic [1:0] control_mode_param, zero_speed_function_param, pulse_format_param;
    logic [1:0] preset_speed_sel;
    logic [15:0] gear_numerator_one, gear_numerator_two;
    logic motor_enable, servo_alarm, alarm_reset_done, position_mode, gain_select;
    logic torque_limit_select, speed_force_zero, forward_permit, reverse_permit;
    logic signed [DEV_W_DEF-1:0] deviation_count, position_cmd;
    int err_total, samples_checked, exp_pos, exp_dev, cyc;

    sci_cmd_input #(.ALM_RST_CYCLES(ALM_N)) uut (
        .core_clk, .sys_rst, .run_in, .alarm_reset_in, .deviation_clear_in, .gain_switch_in,
        .gear_switch_in, .forward_overtravel_in, .reverse_overtravel_in, .cmd_pair1_in,
        .cmd_pair2_in, .control_mode_param, .zero_speed_function_param, .pulse_format_param,
        .gear_numerator_one, .gear_numerator_two, .alarm_raise, .alarm_clearable,
        .fb_step, .fb_step_fwd, .motor_enable, .servo_alarm, .alarm_reset_done,
        .position_mode, .gain_select, .torque_limit_select, .speed_force_zero,
        .preset_speed_sel, .forward_permit, .reverse_permit, .deviation_count, .position_cmd);
    sci_host host (.core_clk, .cmd_pair1_in, .cmd_pair2_in, .gear_switch_in,
        .alarm_reset_in, .deviation_clear_in);

    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Done is a one-cycle pulse, so it is caught here
    always @(posedge core_clk) if (alarm_reset_done === 1'b1) done_seen <= 1'b1;
    // Hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // Wait n edges, then settle at the falling edge before looking
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : wt
    task automatic move(input logic [1:0] f, input int n, input logic fwd, input logic take,
            input int num);
        @(posedge core_clk);
        pulse_format_param <= f;
        host.pulses(f, n, fwd);
        wt(6);
        if (take) begin
            exp_pos += fwd ? n : -n;
            exp_dev += fwd ? n * num : -n * num;
        end
        check(position_cmd, exp_pos);
        check(deviation_count, exp_dev);
    endtask : move
    task automatic raise(input logic c);
        @(posedge core_clk);
        alarm_raise <= 1'b1;
        alarm_clearable <= c;
        @(posedge core_clk);
        alarm_raise <= 1'b0;
        wt(4);
        check(servo_alarm, 1'b1);
        check(motor_enable, 1'b0);
    endtask : raise

    // Main sequence
    initial begin
        {sys_rst, run_in, gain_switch_in, alarm_raise, alarm_clearable, done_seen} = 6'h20;
        {forward_overtravel_in, reverse_overtravel_in, fb_step, fb_step_fwd} = 4'hc;
        {control_mode_param, zero_speed_function_param, pulse_format_param} = '0;
        gear_numerator_one = 16'h0003;
        gear_numerator_two = 16'h0005;
        {err_total, samples_checked, exp_pos, exp_dev, cyc} = '0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        wt(4);
        check(motor_enable, 1'b0);
        @(posedge core_clk);
        run_in <= 1'b1;
        wt(4);
        check(motor_enable, 1'b1);
        for (int f = 0; f < 3; f++) begin
            move(f[1:0], (f == 2) ? 8 : 3, 1'b1, 1'b1, 3);
            move(f[1:0], (f == 2) ? 4 : 2, 1'b0, 1'b1, 3);
        end
        @(posedge core_clk);
        {fb_step, fb_step_fwd} <= 2'h3;
        @(posedge core_clk);
        fb_step <= 1'b0;
        exp_dev--;
        host.set_gear(1'b1);
        move(FMT_PULSE_DIR, 2, 1'b1, 1'b1, 5);
        host.set_gear(1'b0);
        @(posedge core_clk);
        forward_overtravel_in <= 1'b0;
        wt(4);
        check(forward_permit, 1'b0);
        move(FMT_FWD_REV, 2, 1'b1, 1'b0, 3);
        move(FMT_PULSE_DIR, 1, 1'b0, 1'b1, 3);
        @(posedge core_clk);
        {forward_overtravel_in, reverse_overtravel_in} <= 2'h2;
        wt(4);
        check(reverse_permit, 1'b0);
        move(FMT_QUAD, 4, 1'b0, 1'b0, 3);
        @(posedge core_clk);
        reverse_overtravel_in <= 1'b1;
        host.clear(1'b1);
        exp_dev = 0;
        check(deviation_count, 32'h0000_0000);
        move(FMT_FWD_REV, 2, 1'b1, 1'b0, 3);
        host.clear(1'b0);
        move(FMT_FWD_REV, 1, 1'b1, 1'b1, 3);
        @(posedge core_clk);
        gain_switch_in <= 1'b1;
        wt(6);
        check(gain_select, 1'b1);
        @(posedge core_clk);
        zero_speed_function_param <= ZSF_TLIM;
        wt(4);
        check({gain_select, torque_limit_select}, 2'h1);
        @(posedge core_clk);
        control_mode_param <= MODE_SPEED;
        zero_speed_function_param <= ZSF_ZERO_EN;
        gain_switch_in <= 1'b0;
        wt(8);
        check(position_mode, 1'b0);
        check(speed_force_zero, 1'b1);
        @(posedge core_clk);
        zero_speed_function_param <= ZSF_OFF;
        wt(4);
        check(speed_force_zero, 1'b0);
        for (int i = 0; i < 4; i++) begin
            host.clear(i[1]);
            host.set_gear(i[0]);
            wt(4);
            check(preset_speed_sel, i[1:0]);
        end
        move(FMT_FWD_REV, 2, 1'b1, 1'b0, 3);
        host.clear(1'b0);
        host.set_gear(1'b0);
        @(posedge core_clk);
        control_mode_param <= MODE_POS_B;
        wt(4);
        check(position_mode, 1'b1);
        move(FMT_FWD_REV, 1, 1'b0, 1'b1, 3);
        raise(1'b1);
        host.alm_reset(ALM_N / 2);
        wt(4);
        check(servo_alarm, 1'b1);
        host.alm_reset(ALM_N + 10);
        wt(2);
        check({servo_alarm, done_seen}, 2'h1);
        raise(1'b0);
        host.alm_reset(ALM_N + 10);
        wt(2);
        check(servo_alarm, 1'b1);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        wt(5);
        check({servo_alarm, position_cmd}, '0);
        summarize();
    end
endmodule : sci_cmd_input_bench
